// ===== hdl/fpb_pkg.sv
package fpb_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS     = 25;
  localparam int OP_MAX_NS  = 2_000_000;
  localparam int OP_CYC     = OP_MAX_NS / CLK_NS;
  // ****************************************
  // array geometry, largest variant
  // ****************************************
  localparam int SECT_BYTES  = 2048;
  localparam int NSECT       = 8;
  localparam int PAGE_BYTES  = 64;
  localparam int ARRAY_BYTES = NSECT * SECT_BYTES;
  localparam int LOADER_BYTES = 512;
  localparam int AW          = 14;
  localparam int PW          = 6;
  localparam int SW          = 3;
  // ****************************************
  // register offsets and fields
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DATA = 8'h04;
  localparam logic [7:0] REG_ADRL = 8'h08;
  localparam logic [7:0] REG_ADRH = 8'h0c;
  localparam logic [7:0] REG_BOOT = 8'h10;
  localparam logic [7:0] REG_SEC  = 8'h14;
  localparam logic [7:0] REG_CRC  = 8'h18;
  localparam int CTRL_WHOLE_BIT = 3;
  localparam int CTRL_BUSY_BIT  = 7;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // ****************************************
  // reset values and fixed addresses
  // ****************************************
  localparam logic [7:0]  BOOT_VEC_RST  = 8'h3f;
  localparam logic [7:0]  BOOT_STAT_RST = 8'h01;
  localparam logic [15:0] NORMAL_START  = 16'h0000;
  localparam logic [7:0]  VEC_LOW       = 8'h00;
  localparam logic [15:0] BROM_LO       = 16'hff00;
  localparam logic [15:0] BROM_HI       = 16'hffef;
  localparam logic [15:0] BROM_ENTRY    = 16'hff03;
  localparam logic [7:0]  ERASED        = 8'hff;
  localparam logic [31:0] CRC_POLY      = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT      = 32'hffffffff;
  localparam logic [4:0]  FRAME_LAST    = 5'h1f;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0, CMD_LOAD = 3'h1, CMD_PROG = 3'h2, CMD_ERB = 3'h3,
    CMD_ERP  = 3'h4, CMD_ERS  = 3'h5, CMD_ERC  = 3'h6, CMD_CRC = 3'h7
  } fpb_cmd_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_WAIT = 3'b010, ST_WALK = 3'b100
  } fpb_st_e;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } fpb_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } fpb_axi_rsp_s;
endpackage

// ===== hdl/fpb_flash_ctrl.sv
// Contract
// - array is equal sectors; this build has eight of 2 kB
// - each sector splits into 64-byte pages for page erase and program
// - 64-byte page buffer programs 1 to 64 bytes in one operation
// - erase by byte, page, sector or whole chip
// - every program or erase is timed inside and ends within 2 ms
// - any single byte may be erased and rewritten
// - per-sector security blocks code_code_read_instruction reads of that sector
// - no read-back; 32-bit CRC over one sector or whole array
// - boot status zero at reset starts fetch at 0000H
// - nonzero boot status starts at boot vector high, 00H low
// - boot vector ships pointing at top of user flash
// - boot ROM sits at FF00H..FFEFH, entry at FF03H
// - firmware uses control/status, data and two address registers
// - forced programming entry at power-on acts as nonzero status
// - external programmer reaches flash over two-wire clock/data link
// - loader lives in top 512 bytes and may be erased
`timescale 1ns/10ps
`default_nettype none
module fpb_flash_ctrl
  import fpb_pkg::*;
#(
  parameter int OP_CYCLES = fpb_pkg::OP_CYC
)(
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire fpb_pkg::fpb_axi_req_s axi_req,
  output var  fpb_pkg::fpb_axi_rsp_s axi_rsp,
  input  wire logic                  code_en,
  input  wire logic                  code_code_read_instruction,
  input  wire logic [15:0]           code_addr,
  output var  logic [7:0]            code_rdata,
  output var  logic                  code_in_brom,
  output var  logic [15:0]           start_addr,
  input  wire logic                  isp_force,
  input  wire logic                  ser_clk,
  input  wire logic                  ser_data_i,
  output var  logic                  ser_data_o,
  output var  logic                  ser_data_oe
);
  import fpb_pkg::*;

  localparam logic [16:0] WAIT_CYC = 17'(OP_CYCLES - ARRAY_BYTES - 2);

  // ****************************************
  // storage, nonvolatile elements keep their value over sys_rst
  // ****************************************
  logic [7:0]  mem_q [ARRAY_BYTES];
  logic [7:0]  buf_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] bufv_q;
  logic [NSECT-1:0] sec_q  = '0;
  logic [7:0]  bstat_q     = BOOT_STAT_RST;
  logic [7:0]  bvec_q      = BOOT_VEC_RST;

  fpb_st_e     st_q;
  fpb_cmd_e    op_q;
  logic [16:0] tmr_q;
  logic [AW-1:0] ptr_q, lo_q, hi_q;
  logic [31:0] crc_q;
  logic [7:0]  data_q;
  logic [15:0] addr_q;
  logic        whole_q, busy;

  function automatic logic reg_ok(input logic [7:0] a);
    return a == REG_CTRL || a == REG_DATA || a == REG_ADRL || a == REG_ADRH ||
           a == REG_BOOT || a == REG_SEC || a == REG_CRC;
  endfunction

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
      r = (r[31] ^ d[7-i]) ? ({r[30:0], 1'b0} ^ CRC_POLY) : {r[30:0], 1'b0};
    return r;
  endfunction

  function automatic logic [2*AW-1:0] op_range(input fpb_cmd_e c, input logic w,
                                               input logic [AW-1:0] a);
    logic [AW-1:0] all_hi;
    logic [PW-1:0] z, o;
    all_hi = AW'(ARRAY_BYTES - 1);
    z = '0;
    o = '1;
    case (c)
      CMD_PROG, CMD_ERP: return {a[AW-1:PW], z, a[AW-1:PW], o};
      CMD_ERS: return {a[AW-1:AW-SW], {(AW-SW){1'b0}}, a[AW-1:AW-SW], {(AW-SW){1'b1}}};
      CMD_ERC: return {{AW{1'b0}}, all_hi};
      CMD_CRC: return w ? {{AW{1'b0}}, all_hi}
                        : {a[AW-1:AW-SW], {(AW-SW){1'b0}}, a[AW-1:AW-SW], {(AW-SW){1'b1}}};
      default: return {a, a};
    endcase
  endfunction

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic        awh_q, wh_q, bv_q, rv_q;
  logic [7:0]  awa_q;
  logic [31:0] wd_q, rd_q;
  logic [3:0]  ws_q;
  logic [1:0]  br_q, rr_q;
  logic        wr_fire;

  assign wr_fire = awh_q && wh_q && !bv_q;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      awh_q <= 1'b0;
      wh_q  <= 1'b0;
      bv_q  <= 1'b0;
      br_q  <= RESP_OK;
      awa_q <= '0;
      wd_q  <= '0;
      ws_q  <= '0;
    end
    else
    begin
      if (axi_req.awvalid && !awh_q)
      begin
        awh_q <= 1'b1;
        awa_q <= axi_req.awaddr;
      end
      if (axi_req.wvalid && !wh_q)
      begin
        wh_q <= 1'b1;
        wd_q <= axi_req.wdata;
        ws_q <= axi_req.wstrb;
      end
      if (wr_fire)
      begin
        awh_q <= 1'b0;
        wh_q  <= 1'b0;
        bv_q  <= 1'b1;
        br_q  <= reg_ok(awa_q) ? RESP_OK : RESP_ERR;
      end
      else if (bv_q && axi_req.bready)
        bv_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rv_q <= 1'b0;
      rd_q <= '0;
      rr_q <= RESP_OK;
    end
    else if (axi_req.arvalid && !rv_q)
    begin
      rv_q <= 1'b1;
      rr_q <= reg_ok(axi_req.araddr) ? RESP_OK : RESP_ERR;
      case (axi_req.araddr)
        REG_CTRL: rd_q <= 32'({busy, 3'h0, whole_q, op_q});
        REG_DATA: rd_q <= 32'(data_q);
        REG_ADRL: rd_q <= 32'(addr_q[7:0]);
        REG_ADRH: rd_q <= 32'(addr_q[15:8]);
        REG_BOOT: rd_q <= 32'({bvec_q, bstat_q});
        REG_SEC:  rd_q <= 32'(sec_q);
        REG_CRC:  rd_q <= crc_q;
        default:  rd_q <= '0;
      endcase
    end
    else if (rv_q && axi_req.rready)
      rv_q <= 1'b0;
  end

  always_comb
  begin
    axi_rsp.awready = !awh_q;
    axi_rsp.wready  = !wh_q;
    axi_rsp.bvalid  = bv_q;
    axi_rsp.bresp   = br_q;
    axi_rsp.arready = !rv_q;
    axi_rsp.rvalid  = rv_q;
    axi_rsp.rdata   = rd_q;
    axi_rsp.rresp   = rr_q;
  end

  // ****************************************
  // two-wire programming link
  // ****************************************
  logic       sck1_q, sck2_q, sck3_q, sdi1_q, sdi2_q;
  logic [30:0] sr_q;
  logic [4:0]  cnt_q;
  logic        rise, lnk_go, lnk_own_q;
  logic [31:0] frame;

  assign rise   = sck2_q && !sck3_q;
  assign frame  = {sr_q, sdi2_q};
  assign lnk_go = rise && cnt_q == FRAME_LAST;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      {sck1_q, sck2_q, sck3_q, sdi1_q, sdi2_q} <= '0;
      sr_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      {sck1_q, sck2_q, sck3_q} <= {ser_clk, sck1_q, sck2_q};
      {sdi1_q, sdi2_q} <= {ser_data_i, sdi1_q};
      if (rise)
      begin
        sr_q  <= frame[30:0];
        cnt_q <= cnt_q + 5'h1;
      end
    end
  end

  // ****************************************
  // command issue, register writes
  // ****************************************
  logic        axi_go, go;
  fpb_cmd_e    cmd;
  logic        cwhole;
  logic [AW-1:0] caddr;
  logic [7:0]  cdata;
  logic [2*AW-1:0] crange;

  assign axi_go = wr_fire && awa_q == REG_CTRL && ws_q[0];
  assign go     = (axi_go || lnk_go) && st_q == ST_IDLE;
  assign cmd    = axi_go ? fpb_cmd_e'(wd_q[2:0]) : fpb_cmd_e'(frame[31:29]);
  assign cwhole = axi_go ? wd_q[CTRL_WHOLE_BIT] : frame[28];
  assign caddr  = axi_go ? addr_q[AW-1:0] : frame[AW+7:8];
  assign cdata  = axi_go ? data_q : frame[7:0];
  assign crange = op_range(cmd, cwhole, caddr);
  assign busy   = st_q != ST_IDLE;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      data_q  <= '0;
      addr_q  <= '0;
      whole_q <= 1'b0;
    end
    else if (wr_fire && ws_q[0])
    begin
      case (awa_q)
        REG_DATA: data_q <= wd_q[7:0];
        REG_ADRL: addr_q[7:0] <= wd_q[7:0];
        REG_ADRH: addr_q[15:8] <= wd_q[7:0];
        REG_CTRL: whole_q <= wd_q[CTRL_WHOLE_BIT];
        default: ;
      endcase
    end
  end

  // boot elements are written by the programming party, never by reset
  always_ff @(posedge mclk)
  begin
    if (wr_fire && !busy && awa_q == REG_BOOT)
    begin
      if (ws_q[0])
        bstat_q <= wd_q[7:0];
      if (ws_q[1])
        bvec_q <= wd_q[15:8];
    end
    if (st_q == ST_WALK && op_q == CMD_ERC && ptr_q == hi_q)
      sec_q <= '0;
    else if (wr_fire && !busy && awa_q == REG_SEC && ws_q[0])
      sec_q <= wd_q[NSECT-1:0];
  end

  // ****************************************
  // operation sequencer
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_q  <= ST_IDLE;
      op_q  <= CMD_NONE;
      tmr_q <= '0;
      ptr_q <= '0;
      lo_q  <= '0;
      hi_q  <= '0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
          if (go && cmd != CMD_NONE && cmd != CMD_LOAD)
          begin
            op_q  <= cmd;
            {lo_q, hi_q} <= crange;
            ptr_q <= crange[2*AW-1:AW];
            tmr_q <= WAIT_CYC;
            st_q  <= ST_WAIT;
          end
        ST_WAIT:
          if (tmr_q == '0)
            st_q <= ST_WALK;
          else
            tmr_q <= tmr_q - 17'h1;
        ST_WALK:
          if (ptr_q == hi_q)
            st_q <= ST_IDLE;
          else
            ptr_q <= ptr_q + AW'(1);
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // erase leaves the loader range writable too
  always_ff @(posedge mclk)
  begin
    if (st_q == ST_WALK && op_q inside {CMD_ERB, CMD_ERP, CMD_ERS, CMD_ERC})
      mem_q[ptr_q] <= ERASED;
    else if (st_q == ST_WALK && op_q == CMD_PROG && bufv_q[ptr_q[PW-1:0]])
      mem_q[ptr_q] <= buf_q[ptr_q[PW-1:0]];
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      bufv_q <= '0;
    else if (go && cmd == CMD_LOAD)
    begin
      buf_q[caddr[PW-1:0]]  <= cdata;
      bufv_q[caddr[PW-1:0]] <= 1'b1;
    end
    else if (st_q == ST_WALK && op_q == CMD_PROG && ptr_q == hi_q)
      bufv_q <= '0;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      crc_q <= '0;
    else if (go && cmd == CMD_CRC)
      crc_q <= CRC_INIT;
    else if (st_q == ST_WALK && op_q == CMD_CRC)
      crc_q <= crc_byte(crc_q, mem_q[ptr_q]);
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      lnk_own_q <= 1'b0;
    else if (go && !axi_go && cmd != CMD_LOAD && cmd != CMD_NONE)
      lnk_own_q <= 1'b1;
    else if (!busy)
      lnk_own_q <= 1'b0;
  end
  // link end sees busy of a link-issued op as data held low
  assign ser_data_o  = 1'b0;
  assign ser_data_oe = lnk_own_q && busy;

  // ****************************************
  // code reads and start address
  // ****************************************
  logic brom_hit;
  assign brom_hit = code_addr >= BROM_LO && code_addr <= BROM_HI;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      code_rdata   <= '0;
      code_in_brom <= 1'b0;
    end
    else if (code_en)
    begin
      code_in_brom <= brom_hit;
      if (brom_hit || code_addr >= 16'(ARRAY_BYTES))
        code_rdata <= '0;
      else if (code_code_read_instruction && sec_q[code_addr[AW-1:AW-SW]])
        code_rdata <= '0;
      else
        code_rdata <= mem_q[code_addr[AW-1:0]];
    end
  end

  logic isp1_q, isp2_q;
  always_ff @(posedge mclk)
  begin
    {isp1_q, isp2_q} <= {isp_force, isp1_q};
    if (sys_rst)
      start_addr <= (bstat_q != '0 || isp2_q) ? {bvec_q, VEC_LOW}
                                             : NORMAL_START;
  end

  // ****************************************
  // checks
  // ****************************************
  property p_busy_go;
    @(posedge mclk) disable iff (sys_rst)
      go && cmd inside {CMD_PROG, CMD_ERB, CMD_ERP, CMD_ERS, CMD_ERC, CMD_CRC}
      |=> busy && op_q == $past(cmd);
  endproperty
  a_busy_go: assert property (p_busy_go) else $error("op not started");

  property p_wait_end;
    @(posedge mclk) disable iff (sys_rst)
      st_q == ST_WAIT && tmr_q == '0 |=> st_q == ST_WALK;
  endproperty
  a_wait_end: assert property (p_wait_end) else $error("wait overran");

  logic [17:0] opc_q;
  always_ff @(posedge mclk)
    opc_q <= (sys_rst || !busy) ? '0 : opc_q + 18'h1;
  property p_op_len;
    @(posedge mclk) disable iff (sys_rst) opc_q <= 18'(OP_CYCLES);
  endproperty
  a_op_len: assert property (p_op_len) else $error("op longer than limit");

  property p_secure;
    @(posedge mclk) disable iff (sys_rst)
      code_en && code_code_read_instruction && sec_q[code_addr[AW-1:AW-SW]] |=> code_rdata == '0;
  endproperty
  a_secure: assert property (p_secure) else $error("secured byte leaked");

  property p_boot_zero;
    @(posedge mclk)
      $past(sys_rst) && !sys_rst && $past(bstat_q) == '0 && !$past(isp2_q)
      |-> start_addr == NORMAL_START;
  endproperty
  a_boot_zero: assert property (p_boot_zero) else $error("bad normal start");

  property p_boot_vec;
    @(posedge mclk)
      $past(sys_rst) && !sys_rst && ($past(bstat_q) != '0 || $past(isp2_q))
      |-> start_addr == {$past(bvec_q), VEC_LOW};
  endproperty
  a_boot_vec: assert property (p_boot_vec) else $error("bad vector start");

  property p_brom;
    @(posedge mclk) disable iff (sys_rst)
      code_en && code_addr == BROM_ENTRY |=> code_in_brom;
  endproperty
  a_brom: assert property (p_brom) else $error("entry not in rom");

  property p_page;
    @(posedge mclk) disable iff (sys_rst)
      st_q == ST_WALK && op_q == CMD_PROG |-> ptr_q[AW-1:PW] == lo_q[AW-1:PW];
  endproperty
  a_page: assert property (p_page) else $error("program left its page");

  property p_load;
    @(posedge mclk) disable iff (sys_rst)
      go && cmd == CMD_LOAD |=> bufv_q[$past(caddr[PW-1:0])];
  endproperty
  a_load: assert property (p_load) else $error("buffer byte not held");
endmodule
`default_nettype wire

// ===== tb/fpb_link_prog.sv
`timescale 1ns/10ps
`default_nettype none
module fpb_link_prog (
  input  wire logic mclk,
  output var  logic ser_clk,
  output var  logic ser_data
);
  // ****************************************
  // two-wire programmer
  // ****************************************
  // clock stands low between frames
  initial
  begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
  end

  // levels held 4 mclk each, the far end syncs through two flops
  task automatic send(input logic [31:0] f);
    int i;
    for (i = 31; i >= 0; i--)
    begin
      repeat (4) @(posedge mclk);
      ser_data <= f[i];
      repeat (4) @(posedge mclk);
      ser_clk <= 1'b1;
      repeat (4) @(posedge mclk);
      ser_clk <= 1'b0;
    end
    repeat (4) @(posedge mclk);
    // released line must not keep showing the last bit
    ser_data <= ~f[0];
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import fpb_pkg::*;
  localparam int OPC = 16500;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} fpb_row_s;
  fpb_row_s     rows [4];
  logic         mclk;
  logic         sys_rst;
  fpb_axi_req_s req;
  fpb_axi_rsp_s rsp;
  logic         code_en;
  logic         code_code_read_instruction;
  logic [15:0]  code_addr;
  logic [7:0]   code_rdata;
  logic         code_in_brom;
  logic [15:0]  start_addr;
  logic         isp_force;
  logic         ser_clk;
  logic         prog_d;
  logic         ser_o;
  logic         ser_oe;
  wire logic    ser_line;
  int           err_count;
  int           comparisons;
  logic [31:0]  d;
  logic [1:0]   r;

  // open-drain style: device pulls the data line low while enabled
  assign ser_line = ser_oe ? ser_o : prog_d;

  fpb_flash_ctrl #(.OP_CYCLES(OPC)) uut (
    .mclk(mclk), .sys_rst(sys_rst), .axi_req(req), .axi_rsp(rsp),
    .code_en(code_en), .code_code_read_instruction(code_code_read_instruction), .code_addr(code_addr),
    .code_rdata(code_rdata), .code_in_brom(code_in_brom), .start_addr(start_addr),
    .isp_force(isp_force), .ser_clk(ser_clk), .ser_data_i(ser_line),
    .ser_data_o(ser_o), .ser_data_oe(ser_oe)
  );

  fpb_link_prog prog (.mclk(mclk), .ser_clk(ser_clk), .ser_data(prog_d));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ****************************************
  // checks and bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkr(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask

  task stop_test;
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rr);
    int n;
    n = 0;
    @(posedge mclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    while (n < 64)
    begin
      @(posedge mclk);
      n++;
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1)
        break;
    end
    req.bready <= 1'b0;
    rr = (n < 64) ? rsp.bresp : 2'bxx;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
    int n;
    n = 0;
    @(posedge mclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    while (n < 64)
    begin
      @(posedge mclk);
      n++;
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1)
        break;
    end
    req.arvalid <= 1'b0;
    req.rready <= 1'b0;
    v = (n < 64) ? rsp.rdata : 32'hx;
    rr = rsp.rresp;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0]  rr;
    axr(a, v, rr);
    chk(v, exp);
    chkr(rr, RESP_OK);
  endtask

  task automatic cmd(input logic [13:0] a, input logic [7:0] v, input fpb_cmd_e c);
    logic [1:0] rr;
    axw(REG_ADRL, {24'h0, a[7:0]}, rr);
    axw(REG_ADRH, {26'h0, a[13:8]}, rr);
    axw(REG_DATA, {24'h0, v}, rr);
    axw(REG_CTRL, {29'h0, c}, rr);
  endtask

  // polls busy; the whole operation must fit in OPC cycles
  task automatic wait_idle;
    logic [31:0] v;
    logic [1:0]  rr;
    time         t0;
    int          n;
    t0 = $time;
    n = 0;
    do
    begin
      axr(REG_CTRL, v, rr);
      n++;
    end
    while (v[CTRL_BUSY_BIT] !== 1'b0 && n < OPC);
    chk({31'h0, ($time - t0) <= OPC * 25}, 32'h1);
  endtask

  task automatic code(input logic [15:0] a, input logic mv, input logic [7:0] exp);
    @(posedge mclk);
    code_en <= 1'b1;
    code_code_read_instruction <= mv;
    code_addr <= a;
    @(posedge mclk);
    code_en <= 1'b0;
    #1;
    chk({24'h0, code_rdata}, {24'h0, exp});
  endtask

  task automatic rst;
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
  endtask

  function automatic logic [31:0] crc_ff(input int n);
    logic [31:0] c;
    int          i;
    int          b;
    c = CRC_INIT;
    for (i = 0; i < n; i++)
    begin
      c = c ^ {ERASED, 24'h0};
      for (b = 0; b < 8; b++)
        c = c[31] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    rows = '{'{REG_BOOT, 32'h3f01, RESP_OK}, '{REG_SEC, 32'h0, RESP_OK},
             '{8'h1c, 32'h0, RESP_ERR}, '{8'h20, 32'h0, RESP_ERR}};
    err_count = 0;
    comparisons = 0;
    req = '0;
    sys_rst = 1'b1;
    code_en = 1'b0;
    code_code_read_instruction = 1'b0;
    code_addr = 16'h0000;
    isp_force = 1'b0;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (rows[i])
    begin
      axr(rows[i].a, d, r);
      chk(d, rows[i].d);
      chkr(r, rows[i].r);
    end
    axw(8'h1c, 32'h1, r);
    chkr(r, RESP_ERR);
    // both ends of one page through the buffer
    cmd(14'h0040, 8'h5a, CMD_LOAD);
    cmd(14'h007f, 8'ha5, CMD_LOAD);
    cmd(14'h0040, 8'h00, CMD_PROG);
    rchk(REG_CTRL, 32'h82);
    wait_idle;
    code(16'h0040, 1'b0, 8'h5a);
    code(16'h007f, 1'b0, 8'ha5);
    cmd(14'h0040, 8'h00, CMD_ERB);
    wait_idle;
    code(16'h0040, 1'b0, ERASED);
    code(16'h007f, 1'b0, 8'ha5);
    axw(REG_SEC, 32'h1, r);
    code(16'h007f, 1'b1, 8'h00);
    code(16'h007f, 1'b0, 8'ha5);
    code(BROM_ENTRY, 1'b0, 8'h00);
    chk({31'h0, code_in_brom}, 32'h1);
    prog.send({3'h3, 1'b0, 6'h0, 14'h007f, 8'h00});
    chk({31'h0, ser_oe}, 32'h1);
    chk({31'h0, ser_line}, 32'h0);
    wait_idle;
    chk({31'h0, ser_oe}, 32'h0);
    code(16'h007f, 1'b0, ERASED);
    // page and sector erase in an unsecured sector
    cmd(14'h0800, 8'h3c, CMD_LOAD);
    cmd(14'h0800, 8'h00, CMD_PROG);
    wait_idle;
    cmd(14'h0841, 8'hc3, CMD_LOAD);
    cmd(14'h0841, 8'h00, CMD_PROG);
    wait_idle;
    code(16'h0800, 1'b1, 8'h3c);
    cmd(14'h0800, 8'h00, CMD_ERP);
    wait_idle;
    code(16'h0800, 1'b0, ERASED);
    code(16'h0841, 1'b0, 8'hc3);
    chk({31'h0, code_in_brom}, 32'h0);
    cmd(14'h0fff, 8'h00, CMD_ERS);
    wait_idle;
    code(16'h0841, 1'b0, ERASED);
    cmd(14'h0800, 8'h00, CMD_CRC);
    wait_idle;
    rchk(REG_CRC, crc_ff(SECT_BYTES));
    // commands and nonvolatile writes during busy are dropped
    cmd(14'h0000, 8'h00, CMD_ERC);
    axw(REG_CTRL, {29'h0, CMD_ERP}, r);
    axw(REG_BOOT, 32'h3f00, r);
    wait_idle;
    rchk(REG_CTRL, {29'h0, CMD_ERC});
    rchk(REG_BOOT, 32'h3f01);
    rchk(REG_SEC, 32'h0);
    code(16'h3fff, 1'b0, ERASED);
    axw(REG_CTRL, 32'h1 << CTRL_WHOLE_BIT | {29'h0, CMD_CRC}, r);
    wait_idle;
    rchk(REG_CRC, crc_ff(ARRAY_BYTES));
    rst;
    chk({16'h0, start_addr}, 32'h3f00);
    axw(REG_BOOT, 32'h3f00, r);
    rst;
    chk({16'h0, start_addr}, {16'h0, NORMAL_START});
    @(posedge mclk);
    isp_force <= 1'b1;
    rst;
    chk({16'h0, start_addr}, {16'h0, BOOT_VEC_RST, VEC_LOW});
    stop_test;
  end

  initial
  begin
    // two whole-array ops of OPC each, smaller ops and polling stay well inside
    repeat (60000) @(posedge mclk);
    err_count++;
    stop_test;
  end
endmodule
`default_nettype wire
